/* src/otrd_pkg.sv */
package otrd_pkg;
  // Field positions within the low 12 bits of the instruction word
  localparam int SRC1_FILE_HI = 11;
  localparam int SRC1_FILE_LO = 10;
  localparam int SRC0_TYPE_HI = 9;
  localparam int SRC0_TYPE_LO = 7;
  localparam int SRC0_FILE_HI = 6;
  localparam int SRC0_FILE_LO = 5;
  localparam int DST_TYPE_HI  = 4;
  localparam int DST_TYPE_LO  = 2;
  localparam int DST_FILE_HI  = 1;
  localparam int DST_FILE_LO  = 0;
  localparam int WORD_W       = 12;

  // Register-file selector codes
  localparam logic [1:0] FILE_ARCH = 2'h0;
  localparam logic [1:0] FILE_GEN  = 2'h1;
  localparam logic [1:0] FILE_MSG  = 2'h2;
  localparam logic [1:0] FILE_LIT  = 2'h3;

  // Numeric type codes (register operands and destination)
  localparam logic [2:0] TY_UDW  = 3'h0;
  localparam logic [2:0] TY_SDW  = 3'h1;
  localparam logic [2:0] TY_U16  = 3'h2;
  localparam logic [2:0] TY_SW   = 3'h3;
  localparam logic [2:0] TY_U8   = 3'h4;
  localparam logic [2:0] TY_SB   = 3'h5;
  localparam logic [2:0] TY_RSV  = 3'h6;
  localparam logic [2:0] TY_FLT  = 3'h7;
  // Literal-only reinterpretations
  localparam logic [2:0] TY_LIT_FVEC = 3'h5;
  localparam logic [2:0] TY_LIT_V4   = 3'h6;

  // Reset values of the registered outputs
  localparam logic [1:0] RST_FILE = 2'h0;
  localparam logic [2:0] RST_TYPE = 3'h0;

  // Decoded operand file class
  typedef enum logic [1:0] {
    OTRD_ARCH, OTRD_GEN, OTRD_MSG, OTRD_NONE
  } otrd_file_t;
endpackage : otrd_pkg

/* src/otrd_file_dec.sv */
`timescale 1ns/1ps
// Turns one two-bit selector into one-hot file flags
module otrd_file_dec
  import otrd_pkg::*;
(
  // Selector in
  input  wire logic [1:0] i_sel,
  // Decoded flags
  output logic            o_arch,
  output logic            o_gen,
  output logic            o_msg,
  output logic            o_top
);
  // Plain decode; the top code means literal or reserved by context
  always_comb
  begin
    o_arch = (i_sel == FILE_ARCH);
    o_gen  = (i_sel == FILE_GEN);
    o_msg  = (i_sel == FILE_MSG);
    o_top  = (i_sel == FILE_LIT);
  end
endmodule : otrd_file_dec

/* src/otrd_decoder.sv */
`timescale 1ns/1ps
// How it works
// - second source file from bits 11:10
// - second source code 11 means literal
// - first source type 9:7, file 6:5
// - destination type taken from bits 4:2
// - destination type codes; 110 reserved
// - destination type passed through, never converted
// - message-issue: type goes to current target
// - destination file from 1:0; 11 reserved
// - message-issue: file goes to writeback target
// - register source types match destination codes
// - literal types 101 vector float, 110 nibbles
module otrd_decoder
  import otrd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  // Instruction from fetch
  input  wire logic              i_valid,
  input  wire logic [WORD_W-1:0] i_word,
  input  wire logic              i_msg_issue,
  // Second source
  output logic [1:0]             o_second_source_file_select,
  output logic                   o_second_source_literal,
  // First source
  output logic [2:0]             o_first_source_type,
  output logic [1:0]             o_first_source_file_select,
  output logic                   o_first_source_literal,
  output logic                   o_first_source_float_vector,
  output logic                   o_first_source_v4,
  // Destination type and file
  output logic [2:0]             o_target_type,
  output logic [1:0]             o_target_file_select,
  // Routing for message issue
  output logic                   o_type_to_current_target,
  output logic                   o_file_to_writeback_target,
  // Status
  output logic                   o_valid,
  output logic                   o_illegal
);
  // Registered decode state
  logic [1:0] s1_file_reg, s1_file_next;
  logic       s1_lit_reg,  s1_lit_next;
  logic [2:0] s0_type_reg, s0_type_next;
  logic [1:0] s0_file_reg, s0_file_next;
  logic       s0_lit_reg,  s0_lit_next;
  logic       s0_fvec_reg, s0_fvec_next;
  logic       s0_v4_reg,   s0_v4_next;
  logic [2:0] dt_reg,      dt_next;
  logic [1:0] df_reg,      df_next;
  logic       cur_reg,     cur_next;
  logic       wb_reg,      wb_next;
  logic       vld_reg,     vld_next;
  logic       ill_reg,     ill_next;

  // Field slices of the incoming word
  logic [1:0] f_s1_file;
  logic [2:0] f_s0_type;
  logic [1:0] f_s0_file;
  logic [2:0] f_dt;
  logic [1:0] f_df;
  // One-hot views from the shared selector decoder
  logic       s1_top;
  logic       s0_top;
  logic       df_top;

  assign f_s1_file = i_word[SRC1_FILE_HI:SRC1_FILE_LO];
  assign f_s0_type = i_word[SRC0_TYPE_HI:SRC0_TYPE_LO];
  assign f_s0_file = i_word[SRC0_FILE_HI:SRC0_FILE_LO];
  assign f_dt      = i_word[DST_TYPE_HI:DST_TYPE_LO];
  assign f_df      = i_word[DST_FILE_HI:DST_FILE_LO];

  // Selectors side by side so one loop decodes all three
  logic [1:0] sel_arr [3]; // Second source, first source, destination
  logic [2:0] top_vec;     // Top code seen, one bit per selector

  assign sel_arr[0] = f_s1_file;
  assign sel_arr[1] = f_s0_file;
  assign sel_arr[2] = f_df;

  // One shared selector decoder per operand
  for (genvar g = 0; g < 3; g++)
  begin : g_sel_dec
    otrd_file_dec otrd_file_dec_inst (
      .i_sel  (sel_arr[g]),
      .o_arch (),
      .o_gen  (),
      .o_msg  (),
      .o_top  (top_vec[g])
    );
  end

  assign s1_top = top_vec[0];
  assign s0_top = top_vec[1];
  assign df_top = top_vec[2];

  // Next-value logic; fields hold until the next valid word, valid follows i_valid
  always_comb
  begin
    s1_file_next = s1_file_reg;
    s1_lit_next  = s1_lit_reg;
    s0_type_next = s0_type_reg;
    s0_file_next = s0_file_reg;
    s0_lit_next  = s0_lit_reg;
    s0_fvec_next = s0_fvec_reg;
    s0_v4_next   = s0_v4_reg;
    dt_next      = dt_reg;
    df_next      = df_reg;
    cur_next     = cur_reg;
    wb_next      = wb_reg;
    ill_next     = ill_reg;
    vld_next     = i_valid;
    if (i_valid)
    begin
      s1_file_next = f_s1_file;
      // top code marks a literal operand
      s1_lit_next  = s1_top;
      s0_type_next = f_s0_type;
      s0_file_next = f_s0_file;
      s0_lit_next  = s0_top;
      s0_fvec_next = s0_top && (f_s0_type == TY_LIT_FVEC);
      s0_v4_next   = s0_top && (f_s0_type == TY_LIT_V4);
      dt_next      = f_dt;
      df_next      = f_df;
      // type belongs to the current target
      cur_next     = i_msg_issue;
      // file belongs to the writeback target
      wb_next      = i_msg_issue;
      // code 110 is the reserved type
      // a literal destination is also refused here
      ill_next     = (f_dt == TY_RSV) || df_top;
    end
  end

  // Register stage; enable low freezes everything, reset included,
  // so a stalled pipe keeps its decode until it is enabled again
  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      if (!i_rstn)
      begin
        s1_file_reg <= RST_FILE;
        s1_lit_reg  <= 1'b0;
        s0_type_reg <= RST_TYPE;
        s0_file_reg <= RST_FILE;
        s0_lit_reg  <= 1'b0;
        s0_fvec_reg <= 1'b0;
        s0_v4_reg   <= 1'b0;
        dt_reg      <= RST_TYPE;
        df_reg      <= RST_FILE;
        cur_reg     <= 1'b0;
        wb_reg      <= 1'b0;
        vld_reg     <= 1'b0;
        ill_reg     <= 1'b0;
      end
      else
      begin
        s1_file_reg <= s1_file_next;
        s1_lit_reg  <= s1_lit_next;
        s0_type_reg <= s0_type_next;
        s0_file_reg <= s0_file_next;
        s0_lit_reg  <= s0_lit_next;
        s0_fvec_reg <= s0_fvec_next;
        s0_v4_reg   <= s0_v4_next;
        dt_reg      <= dt_next;
        df_reg      <= df_next;
        cur_reg     <= cur_next;
        wb_reg      <= wb_next;
        vld_reg     <= vld_next;
        ill_reg     <= ill_next;
      end
    end
  end

  // Outputs straight from flops
  assign o_second_source_file_select = s1_file_reg;
  assign o_second_source_literal     = s1_lit_reg;
  // register source codes share the destination table
  assign o_first_source_type         = s0_type_reg;
  assign o_first_source_file_select  = s0_file_reg;
  assign o_first_source_literal      = s0_lit_reg;
  assign o_first_source_float_vector = s0_fvec_reg;
  assign o_first_source_v4           = s0_v4_reg;
  assign o_target_type               = dt_reg;
  assign o_target_file_select        = df_reg;
  assign o_type_to_current_target    = cur_reg;
  assign o_file_to_writeback_target  = wb_reg;
  assign o_valid                     = vld_reg;
  assign o_illegal                   = ill_reg;

  // Sequence: a valid word accepted while enabled
  sequence s_take;
    i_ce && i_valid;
  endsequence

  chk_s1_file_sel: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_second_source_file_select == $past(i_word[11:10]))
    else $error("second source file select wrong");
  chk_s1_literal: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_second_source_literal == ($past(i_word[11:10]) == 2'h3))
    else $error("literal flag wrong");
  chk_s0_fields: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_first_source_type == $past(i_word[9:7])
      && o_first_source_file_select == $past(i_word[6:5]))
    else $error("first source fields wrong");
  chk_dst_type: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_target_type == $past(i_word[4:2]))
    else $error("target type wrong");
  chk_dst_file: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_target_file_select == $past(i_word[1:0]))
    else $error("target file wrong");
  chk_msg_route: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_type_to_current_target == $past(i_msg_issue)
      && o_file_to_writeback_target == $past(i_msg_issue))
    else $error("message routing wrong");
  chk_illegal_flag: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take |=> o_illegal == ($past(i_word[4:2]) == 3'h6
      || $past(i_word[1:0]) == 2'h3))
    else $error("illegal flag wrong");
  chk_lit_vector: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take ##1 o_first_source_float_vector |-> o_first_source_literal
      && o_first_source_type == 3'h5)
    else $error("vector float flag wrong");
  chk_lit_nibble: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    s_take ##1 o_first_source_v4 |-> o_first_source_literal
      && o_first_source_type == 3'h6)
    else $error("nibble vector flag wrong");
  chk_hold_frozen: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !i_ce |=> $stable(o_target_type) && $stable(o_valid))
    else $error("state moved while frozen");
  // Reset must not reach the flops either while the enable is low
  chk_reset_frozen: assert property (
    @(posedge i_clk)
    !i_ce |=> $stable(o_illegal) && $stable(o_target_file_select))
    else $error("reset moved state while frozen");
endmodule : otrd_decoder

/* tb/otrd_fetch_model.sv */
`timescale 1ns/1ps
// Fetch side: issues words, scrambles its lines while idle
module otrd_fetch_model
  import otrd_pkg::*;
(
  // Clock
  input  wire logic              i_clk,
  // Bench control
  input  wire logic              i_send,
  input  wire logic              i_break,
  input  wire logic [WORD_W-1:0] i_word_in,
  input  wire logic              i_msg_in,
  // To decoder
  output logic                   o_valid,
  output logic [WORD_W-1:0]      o_word,
  output logic                   o_msg
);
  logic [WORD_W:0] last_reg = '0; // Last issued message flag and word
  logic [WORD_W:0] last_next;
  logic            ok;            // Word may go out
  // Idle lines show the inverse, so stale values never pass for data
  always_comb
  begin
    ok = i_send && (i_break || i_word_in[1:0] != 2'h3);
    last_next = ok ? {i_msg_in, i_word_in} : last_reg;
    o_valid = ok;
    o_word = ok ? i_word_in : ~last_reg[WORD_W-1:0];
    o_msg = ok ? i_msg_in : ~last_reg[WORD_W];
  end
  // Remember what went out
  always_ff @(posedge i_clk)
  begin
    last_reg <= last_next;
  end
endmodule : otrd_fetch_model

/* tb/test_operand_type_regfile_decoder.sv */
`timescale 1ns/1ps
// Drives words through the fetch model and checks each decode
module test_operand_type_regfile_decoder
  import otrd_pkg::*;
;
  logic              i_clk, i_rstn, i_ce, send, brk, msg_in;
  logic [WORD_W-1:0] word_in, f_word;
  logic              f_valid, f_msg;
  logic [1:0]        s1f, s0f, tf;
  logic [2:0]        s0t, tt;
  logic              s1l, s0l, fvec, v4, tcur, fwb, ov, ill;
  int                miscompares = 0;
  int                comparisons = 0;

  otrd_fetch_model otrd_fetch_model_inst (
    .i_clk(i_clk), .i_send(send), .i_break(brk), .i_word_in(word_in),
    .i_msg_in(msg_in), .o_valid(f_valid), .o_word(f_word), .o_msg(f_msg));
  otrd_decoder otrd_decoder_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_valid(f_valid),
    .i_word(f_word), .i_msg_issue(f_msg),
    .o_second_source_file_select(s1f), .o_second_source_literal(s1l),
    .o_first_source_type(s0t), .o_first_source_file_select(s0f),
    .o_first_source_literal(s0l), .o_first_source_float_vector(fvec),
    .o_first_source_v4(v4), .o_target_type(tt),
    .o_target_file_select(tf), .o_type_to_current_target(tcur),
    .o_file_to_writeback_target(fwb), .o_valid(ov), .o_illegal(ill));

  // Free-running 20 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Count and report one comparison
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Drive inputs a fixed delay after the edge
  task automatic put(input logic ce, input logic s, input logic [11:0] w,
                     input logic m, input logic b);
    @(posedge i_clk);
    #2;
    i_ce = ce;
    send = s;
    word_in = w;
    msg_in = m;
    brk = b;
  endtask : put

  // Expected outputs worked out from one word
  task automatic exp_out(input logic [11:0] w, input logic m,
                         input logic v);
    logic l0;
    l0 = (w[6:5] == 2'h3);
    cmp({1'b0, s1l, s1f}, {1'b0, w[11:10] == 2'h3, w[11:10]});
    cmp({1'b0, s0t}, {1'b0, w[9:7]});
    cmp({2'h0, s0f}, {2'h0, w[6:5]});
    cmp({1'b0, s0l, fvec, v4},
        {1'b0, l0, l0 && w[9:7] == 3'h5, l0 && w[9:7] == 3'h6});
    cmp({1'b0, tt}, {1'b0, w[4:2]});
    cmp({2'h0, tf}, {2'h0, w[1:0]});
    cmp({2'h0, tcur, fwb}, {2'h0, m, m});
    cmp({3'h0, ov}, {3'h0, v});
    cmp({3'h0, ill}, {3'h0, w[4:2] == 3'h6 || w[1:0] == 2'h3});
  endtask : exp_out

  // Reset held ten cycles; outputs must read zero
  task automatic t_reset();
    i_rstn = 1'b0;
    repeat (10) put(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    exp_out(12'h000, 1'b0, 1'b0);
    i_rstn = 1'b1;
  endtask : t_reset

  // Back-to-back words covering every type code and literal flags
  task automatic t_codes();
    logic [11:0] w, p;
    for (int k = 0; k < 11; k++)
    begin
      w = {2'(k), 3'(7 - k), 2'(k + 1), 3'(k), 2'(k % 3)};
      if (k == 8)
        w = {2'h3, 3'h6, 2'h3, 3'h7, 2'h1};
      if (k == 9)
        w = {2'h3, 3'h5, 2'h3, 3'h1, 2'h2};
      put(1'b1, k < 10, w, k[0], 1'b0);
      if (k > 0)
        exp_out(p, ~k[0], 1'b1);
      p = w;
    end
  endtask : t_codes

  // Idle words keep fields; a low enable freezes everything
  task automatic t_hold();
    put(1'b1, 1'b1, 12'h5a9, 1'b1, 1'b0);
    put(1'b0, 1'b1, 12'h3c6, 1'b0, 1'b0);
    exp_out(12'h5a9, 1'b1, 1'b1);
    put(1'b1, 1'b0, 12'h3c6, 1'b0, 1'b0);
    exp_out(12'h5a9, 1'b1, 1'b1);
    put(1'b1, 1'b0, 12'h3c6, 1'b0, 1'b0);
    exp_out(12'h5a9, 1'b1, 1'b0);
  endtask : t_hold

  // Fetch forced to send a literal target, which must be flagged
  task automatic t_bad();
    put(1'b1, 1'b1, 12'h2a3, 1'b0, 1'b1);
    put(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    exp_out(12'h2a3, 1'b0, 1'b1);
  endtask : t_bad

  // Mid-run reset: ignored while enable is low, clears once enabled
  task automatic t_rerun();
    put(1'b0, 1'b0, 12'h000, 1'b0, 1'b0);
    i_rstn = 1'b0;
    put(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    exp_out(12'h2a3, 1'b0, 1'b0);
    put(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    exp_out(12'h000, 1'b0, 1'b0);
    i_rstn = 1'b1;
    put(1'b1, 1'b1, 12'h5a9, 1'b1, 1'b0);
    put(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    exp_out(12'h5a9, 1'b1, 1'b1);
  endtask : t_rerun

  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Main sequence
  initial
  begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    send = 1'b0;
    brk = 1'b0;
    msg_in = 1'b0;
    word_in = 12'h000;
    t_reset();
    t_codes();
    t_hold();
    t_bad();
    t_rerun();
    summarize();
  end
endmodule : test_operand_type_regfile_decoder
